// ==== hdl/psb_pkg.sv ====
package psb_pkg;

  // Reset pulse figures; the minimum length is not printed, so this is a plain default.
  localparam int RESET_MIN_NS = 10000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_CNT_W = 16;
  localparam int RESET_EXEC_NS = 2000;
  localparam int RESET_EXEC_CYC = RESET_EXEC_NS / CLK_PERIOD_NS;

  localparam logic INPUT_PULL_LEVEL = 1'b1;
  localparam logic MODE_TXOFF_DEFAULT = 1'b0;
  localparam logic MODE_LOS_DEFAULT = 1'b0;
  localparam int FLAG_W = 8;

  typedef enum logic [1:0] {
    PSB_RUN = 2'b00,
    PSB_HELD = 2'b01,
    PSB_EXEC = 2'b10
  } psb_state_type;

  // Management-side requests carried as one bundle.
  typedef struct packed {
    logic set_txoff_mode;
    logic set_los_mode;
    logic [FLAG_W-1:0] flag_events;
    logic [FLAG_W-1:0] flag_read;
  } psb_mgmt_req_type;

  typedef struct packed {
    logic low_power_request;
    logic transmit_disable;
    logic reset_executing;
    logic select_active;
  } psb_status_type;

endpackage : psb_pkg

// ==== hdl/psb_sync.sv ====
`timescale 1ns/1ps
module psb_sync (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic din,
  output logic dout
);
  import psb_pkg::*;

  logic stage1_r;
  logic stage2_r;

  // Resets to the pulled level so an idle pin looks undriven.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      stage1_r <= INPUT_PULL_LEVEL;
      stage2_r <= INPUT_PULL_LEVEL;
    end else begin
      stage1_r <= din;
      stage2_r <= stage1_r;
    end
  end

  assign dout = stage2_r;

endmodule : psb_sync

// ==== hdl/psb_sideband.sv ====
`timescale 1ns/1ps
module psb_sideband (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic module_select_n,
  input wire logic module_select_n_oe,
  input wire logic module_reset_n,
  input wire logic module_reset_n_oe,
  input wire logic lowpower_txoff_pin,
  input wire logic lowpower_txoff_pin_oe,
  input wire logic rx_signal_loss,
  input wire psb_pkg::psb_mgmt_req_type mgmt_req,
  output logic twi_enable,
  output logic module_present_n_out,
  output logic module_present_n_oe,
  output logic irq_or_los_pin_out,
  output logic irq_or_los_pin_oe,
  output psb_pkg::psb_status_type status,
  output logic [psb_pkg::FLAG_W-1:0] flags
);
  import psb_pkg::*;

  // Undriven pins resolve to the internal pull-up level.
  wire sel_raw = module_select_n_oe ? module_select_n : INPUT_PULL_LEVEL;
  wire rst_raw = module_reset_n_oe ? module_reset_n : INPUT_PULL_LEVEL;
  wire dm_raw = lowpower_txoff_pin_oe ? lowpower_txoff_pin : INPUT_PULL_LEVEL;

  logic sel_s;
  logic rst_s;
  logic dm_s;

  psb_sync u_sync_sel (.sys_clk(sys_clk), .reset(reset), .din(sel_raw), .dout(sel_s));
  psb_sync u_sync_rst (.sys_clk(sys_clk), .reset(reset), .din(rst_raw), .dout(rst_s));
  psb_sync u_sync_dm (.sys_clk(sys_clk), .reset(reset), .din(dm_raw), .dout(dm_s));

  psb_state_type state_r;
  psb_state_type state_nxt;
  logic [RESET_CNT_W-1:0] cnt_r;
  logic [RESET_CNT_W-1:0] cnt_nxt;
  logic txoff_mode_r;
  logic los_mode_r;
  logic [FLAG_W-1:0] flags_r;
  logic twi_enable_r;
  logic irq_oe_r;
  logic present_oe_r;
  psb_status_type status_r;

  wire pulse_long = (cnt_r >= RESET_CNT_W'(RESET_MIN_CYC));
  wire exec_done = (cnt_r >= RESET_CNT_W'(RESET_EXEC_CYC));
  wire executing = (state_r == PSB_EXEC);
  // A pulse shorter than the minimum is ignored and the module keeps running.
  wire full_reset = (state_r == PSB_HELD) && rst_s && pulse_long;
  wire defaults = reset || full_reset;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      PSB_RUN: begin
        cnt_nxt = '0;
        if (!rst_s) begin
          state_nxt = PSB_HELD;
        end
      end
      PSB_HELD: begin
        if (rst_s) begin
          state_nxt = pulse_long ? PSB_EXEC : PSB_RUN;
          cnt_nxt = '0;
        end else if (!pulse_long) begin
          cnt_nxt = cnt_r + RESET_CNT_W'(1);
        end
      end
      PSB_EXEC: begin
        cnt_nxt = cnt_r + RESET_CNT_W'(1);
        if (exec_done) begin
          state_nxt = PSB_RUN;
          cnt_nxt = '0;
        end
      end
      default: begin
        state_nxt = PSB_RUN;
        cnt_nxt = '0;
      end
    endcase
  end

  // Mode changes are refused while the reset is executing or held long.
  wire reset_busy = executing || (state_r == PSB_HELD && pulse_long);
  wire txoff_mode_nxt = defaults ? MODE_TXOFF_DEFAULT
    : ((mgmt_req.set_txoff_mode && !reset_busy) ? 1'b1 : txoff_mode_r);
  wire los_mode_nxt = defaults ? MODE_LOS_DEFAULT
    : ((mgmt_req.set_los_mode && !reset_busy) ? 1'b1 : los_mode_r);

  // A new event wins over a read-clear in the same cycle.
  wire [FLAG_W-1:0] flags_nxt = defaults ? '0
    : ((flags_r & ~mgmt_req.flag_read) | mgmt_req.flag_events);

  wire irq_assert = |flags_nxt;
  // With no flags set the interrupt mode drives released, while the loss mode still follows rx_signal_loss.
  wire los_assert = rx_signal_loss;
  wire pin_low_nxt = los_mode_nxt ? los_assert : irq_assert;

  // Active-high dual-mode input is steered by the current mode.
  wire dm_active = dm_s;
  psb_status_type status_nxt;
  assign status_nxt.low_power_request = dm_active && !txoff_mode_nxt;
  assign status_nxt.transmit_disable = dm_active && txoff_mode_nxt;
  assign status_nxt.reset_executing = (state_nxt == PSB_EXEC);
  assign status_nxt.select_active = !sel_s;

  // The two-wire slave is gated off while deselected or while a reset is executing.
  wire twi_enable_nxt = !sel_s && (state_nxt != PSB_EXEC);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_r <= PSB_RUN;
      cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    txoff_mode_r <= txoff_mode_nxt;
    los_mode_r <= los_mode_nxt;
    flags_r <= flags_nxt;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      twi_enable_r <= 1'b0;
      irq_oe_r <= 1'b0;
      present_oe_r <= 1'b0;
      status_r <= '0;
    end else begin
      twi_enable_r <= twi_enable_nxt;
      irq_oe_r <= pin_low_nxt;
      present_oe_r <= 1'b1;
      status_r <= status_nxt;
    end
  end

  assign twi_enable = twi_enable_r;
  assign module_present_n_out = 1'b0;
  assign module_present_n_oe = present_oe_r;
  assign irq_or_los_pin_out = 1'b0;
  assign irq_or_los_pin_oe = irq_oe_r;
  assign status = status_r;
  assign flags = flags_r;

endmodule : psb_sideband

// ==== testbench/psb_host_model.sv ====
`timescale 1ns/1ps
module psb_host_model #(parameter int WAIT_CYC = 5) (
  input wire logic sys_clk,
  input wire logic [3:0] cmd,
  output logic module_select_n,
  output logic module_select_n_oe,
  output logic module_reset_n,
  output logic module_reset_n_oe,
  output logic lowpower_txoff_pin,
  output logic lowpower_txoff_pin_oe,
  output logic twi_ok
);
  int quiet;
  // A released line settles at the module's own pull-up, never at a stale level.
  assign module_select_n_oe = !cmd[3];
  assign module_reset_n_oe = !cmd[3];
  assign lowpower_txoff_pin_oe = !cmd[3];
  assign module_select_n = cmd[3] | cmd[0];
  assign module_reset_n = cmd[3] | cmd[1];
  assign lowpower_txoff_pin = cmd[3] | cmd[2];
  // Traffic waits out the settling time after any select change.
  always @(posedge sys_clk) quiet <= $changed(module_select_n) ? 0 : quiet + 1;
  assign twi_ok = quiet >= WAIT_CYC;
endmodule : psb_host_model

// ==== testbench/psb_sideband_chk.sv ====
`timescale 1ns/1ps
module psb_sideband_chk (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic module_select_n,
  input wire logic module_reset_n,
  input wire logic lowpower_txoff_pin,
  input wire psb_pkg::psb_mgmt_req_type mgmt_req,
  input wire logic twi_enable,
  input wire logic module_present_n_oe,
  input wire logic irq_or_los_pin_oe,
  input wire psb_pkg::psb_status_type status,
  input wire logic [psb_pkg::FLAG_W-1:0] flags
);
  import psb_pkg::*;
  logic los_r;
  int low_cnt;
  always_ff @(posedge sys_clk) begin
    los_r <= !reset && !status.reset_executing && (los_r || mgmt_req.set_los_mode);
    low_cnt <= (reset || module_reset_n) ? 0 : low_cnt + 1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_sel_enables: assert property (
    (!module_select_n && module_reset_n && !status.reset_executing)[*8] |-> twi_enable) else $error("no enable");
  a_desel_blocks: assert property (
    module_select_n[*4] |-> !twi_enable) else $error("enabled while deselected");
  a_present_low: assert property (
    !$past(reset) |-> module_present_n_oe) else $error("present not driven");
  a_lp_follows: assert property (
    (lowpower_txoff_pin && module_reset_n && !status.transmit_disable && !status.reset_executing)[*8]
    |-> status.low_power_request) else $error("low power missed");
  a_irq_hold: assert property (
    flags != 0 && !los_r && !status.reset_executing |-> irq_or_los_pin_oe) else $error("no interrupt");
  a_irq_release: assert property (
    flags == 0 && !los_r |-> !irq_or_los_pin_oe) else $error("interrupt held");
  a_long_pulse: assert property (
    $rose(module_reset_n) && low_cnt > RESET_MIN_CYC + 4 |-> ##[1:8] status.reset_executing) else $error("no reset");
  a_short_pulse: assert property (
    $rose(module_reset_n) && low_cnt < RESET_MIN_CYC - 10 |-> ##1 (!status.reset_executing)[*6]) else $error("bad reset");
  c_exec: cover property ($rose(status.reset_executing));
  c_flag: cover property (flags != 0 ##1 flags == 0);
  c_los: cover property (los_r && irq_or_los_pin_oe);
endmodule : psb_sideband_chk

// ==== testbench/psb_sideband_tb_top.sv ====
`timescale 1ns/1ps
module psb_sideband_tb_top;
  import psb_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic rx_loss = 1'b0;
  logic [3:0] cmd = 4'h3;
  psb_mgmt_req_type req = '0;
  logic sel_n, sel_oe, rst_n, rst_oe, lp, lp_oe, twi_ok, twi_en, pres_out, pres_oe, irq_oe;
  psb_status_type st;
  logic [FLAG_W-1:0] flags;
  int fails = 0;
  int check_count = 0;
  // Row: pin command (float, power, reset, select), then expected enable and low-power.
  logic [5:0] rows [5] = '{6'h0A, 6'h0C, 6'h1B, 6'h1D, 6'h21};
  always #50 sys_clk = ~sys_clk;
  psb_host_model host_u (.sys_clk, .cmd, .module_select_n(sel_n), .module_select_n_oe(sel_oe), .module_reset_n(rst_n),
    .module_reset_n_oe(rst_oe), .lowpower_txoff_pin(lp), .lowpower_txoff_pin_oe(lp_oe), .twi_ok);
  psb_sideband dut_u (.sys_clk, .reset, .module_select_n(sel_n), .module_select_n_oe(sel_oe), .module_reset_n(rst_n),
    .module_reset_n_oe(rst_oe), .lowpower_txoff_pin(lp), .lowpower_txoff_pin_oe(lp_oe), .rx_signal_loss(rx_loss),
    .mgmt_req(req), .twi_enable(twi_en), .module_present_n_out(pres_out), .module_present_n_oe(pres_oe),
    .irq_or_los_pin_out(), .irq_or_los_pin_oe(irq_oe), .status(st), .flags);
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic step(int n);
    repeat (n) @(negedge sys_clk);
  endtask : step
  task automatic report_and_stop();
    if (fails == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    step(3000);
    fails++;
    report_and_stop();
  end
  initial begin
    step(8);
    reset = 1'b0;
    foreach (rows[i]) begin
      cmd = rows[i][5:2];
      step(1);
      while (!twi_ok) step(1);
      step(2);
      chk({6'h00, twi_en, st.low_power_request}, {6'h00, rows[i][1:0]});
    end
    chk({7'h00, pres_oe ? pres_out : 1'b1}, 8'h00);
    chk({7'h00, st.select_active}, 8'h00);
    cmd = 4'h2;
    req.flag_events = 8'h81;
    step(1);
    chk(flags, 8'h81);
    req.flag_read = 8'h81;
    req.flag_events = 8'h01;
    step(1);
    chk(flags, 8'h01);
    req = '0;
    req.flag_events = 8'h10;
    step(1);
    req = '0;
    cmd = 4'h0;
    step(20);
    cmd = 4'h2;
    step(30);
    chk(flags, 8'h11);
    req.set_txoff_mode = 1'b1;
    step(1);
    req = '0;
    cmd = 4'h6;
    step(8);
    chk({6'h00, st.transmit_disable, st.low_power_request}, 8'h02);
    cmd = 4'h4;
    step(RESET_MIN_CYC + 5);
    cmd = 4'h6;
    step(6);
    req.set_txoff_mode = 1'b1;
    chk({6'h00, st.reset_executing, twi_en}, 8'h02);
    step(1);
    req = '0;
    step(40);
    chk({st.transmit_disable, st.low_power_request, flags[5:0]}, 8'h40);
    req.set_los_mode = 1'b1;
    step(1);
    req = '0;
    step(2);
    chk({7'h00, irq_oe}, 8'h00);
    rx_loss = 1'b1;
    step(3);
    chk({7'h00, irq_oe}, 8'h01);
    report_and_stop();
  end
endmodule : psb_sideband_tb_top
bind psb_sideband psb_sideband_chk chk_u (.sys_clk, .reset, .module_select_n, .module_reset_n, .lowpower_txoff_pin,
  .mgmt_req, .twi_enable, .module_present_n_oe, .irq_or_los_pin_oe, .status, .flags);
